// ---- design/lbm_pkg.sv ----
// Constants, field positions and types of the LED and button mode controller.
// Assumes a single 125 MHz clock and APB register access with 32-bit data.
package lbm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned LIT_TIMEOUT_S = 15;
    localparam int unsigned LIT_TIMEOUT_MS = LIT_TIMEOUT_S * 1000;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned LONG_PRESS_MS = 2000;
    localparam int unsigned FAST_HALF_MS = 250;
    localparam int unsigned SLOW_HALF_MS = 1000;

    // ------------------------------------------------------------
    // Level thresholds in percent
    // ------------------------------------------------------------
    localparam logic [6:0] LVL_SEG4 = 7'h50;
    localparam logic [6:0] LVL_SEG3 = 7'h3c;
    localparam logic [6:0] LVL_SEG2 = 7'h28;
    localparam logic [6:0] LVL_SEG1 = 7'h14;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_MODE = 12'h004;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
    localparam int unsigned CTRL_W = 3;
    localparam int unsigned CTRL_PUSH_BIT = 0;
    localparam int unsigned CTRL_BAR_SIG_BIT = 1;
    localparam int unsigned CTRL_OTA_TX_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_LIGHT_BIT = 0;
    localparam int unsigned IRQ_LONG_BIT = 1;
    localparam int unsigned IRQ_MODE_BIT = 2;
    localparam int unsigned IRQ_DARK_BIT = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ------------------------------------------------------------
    // Modes and actions
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LBM_NORMAL = 2'b00,
        LBM_SURVEY = 2'b01,
        LBM_OTA = 2'b11
    } lbm_mode_t;
    localparam int unsigned ACT_W = 5;
    localparam int unsigned ACT_BATT_READ = 0;
    localparam int unsigned ACT_SURVEY_TX = 1;
    localparam int unsigned ACT_CFG_TX = 2;
    localparam int unsigned ACT_OTA_RESET = 3;
    localparam int unsigned ACT_FW_TX = 4;

endpackage

// ---- design/lbm_btn_if.sv ----
// Carrier between the press classifier and the controller.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface lbm_btn_if;
    logic tick;
    logic light_press;
    logic long_press;
    modport src (input tick, output light_press, output long_press);
    modport sink (output tick, input light_press, input long_press);
endinterface

// ---- design/lbm_button.sv ----
// Push button synchroniser, debouncer and light/long press classifier.
// Assumes an active-low button pin and a one-cycle millisecond tick.
`timescale 1ns/10ps
module lbm_button
    import lbm_pkg::*;
#(
    parameter int unsigned DEB_MS = DEBOUNCE_MS,
    parameter int unsigned LONG_MS = LONG_PRESS_MS
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Button pin
    input wire logic btn_n,
    // Press events
    lbm_btn_if.src bus
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [7:0] deb_cnt;
        logic [15:0] hold_cnt;
        logic long_done;
        logic light;
        logic lng;
    } lbm_btn_state_t;

    lbm_btn_state_t s_q;
    lbm_btn_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.sync1 = ~btn_n;
        s_d.sync2 = s_q.sync1;
        s_d.light = 1'b0;
        s_d.lng = 1'b0;
        // The pressed level must stay unchanged for the debounce time to count.
        if (s_q.sync2 == s_q.stable)
        begin
            s_d.deb_cnt = 8'h00;
        end
        else if (bus.tick)
        begin
            if (s_q.deb_cnt == 8'(DEB_MS - 1))
            begin
                s_d.deb_cnt = 8'h00;
                s_d.stable = s_q.sync2;
                if (!s_q.sync2 && !s_q.long_done)
                begin
                    s_d.light = 1'b1;
                end
            end
            else
            begin
                s_d.deb_cnt = s_q.deb_cnt + 8'h01;
            end
        end
        if (!s_q.stable)
        begin
            s_d.hold_cnt = 16'h0000;
            s_d.long_done = 1'b0;
        end
        else if (bus.tick && !s_q.long_done)
        begin
            if (s_q.hold_cnt == 16'(LONG_MS - 1))
            begin
                // Long press fires while still held; the release then stays silent.
                s_d.long_done = 1'b1;
                s_d.lng = 1'b1;
            end
            else
            begin
                s_d.hold_cnt = s_q.hold_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus.light_press = s_q.light;
    assign bus.long_press = s_q.lng;

endmodule // lbm_button

// ---- design/lbm_ctrl.sv ----
// LED indicator and single-button mode controller of a wireless end node.
// Assumes status inputs come from logic on pclk and registers sit on APB.
//
// What this block does
// - One push button is the only local control.
// - Presses change LED display and operation mode.
// - On battery, LEDs go dark after 15 s.
// - Normal mode: transmit LED on while pushing data.
// - Site survey: transmit LED on while pushing data.
// - Yellow bar lights one segment per 20 percent.
`timescale 1ns/10ps
module lbm_ctrl
    import lbm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned LIT_MS = LIT_TIMEOUT_MS,
    parameter int unsigned DEB_MS = DEBOUNCE_MS,
    parameter int unsigned LONG_MS = LONG_PRESS_MS,
    parameter int unsigned FAST_MS = FAST_HALF_MS,
    parameter int unsigned SLOW_MS = SLOW_HALF_MS
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Front panel
    input wire logic btn_n,
    output logic led_status,
    output logic led_error,
    output logic led_rx,
    output logic led_tx,
    output logic [3:0] led_bar,
    // Node status
    input wire logic on_battery,
    input wire logic node_ready,
    input wire logic tx_busy,
    input wire logic rf_error,
    input wire logic io_error,
    input wire logic batt_low,
    input wire logic ota_fail,
    input wire logic [6:0] battery_pct,
    input wire logic [6:0] signal_pct,
    // Actions and interrupt
    output logic [4:0] act,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [16:0] tick_cnt;
        logic tick;
        logic [9:0] fast_cnt;
        logic fast;
        logic [9:0] slow_cnt;
        logic slow;
        lbm_mode_t mode;
        logic lit;
        logic [15:0] dark_cnt;
        logic [2:0] ctrl;
        logic [3:0] mask;
        logic [3:0] stat;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic st;
        logic er;
        logic rx;
        logic tx;
        logic [3:0] bar;
        logic [4:0] act;
        logic irq;
    } lbm_state_t;

    lbm_state_t s_q;
    lbm_state_t s_d;

    lbm_btn_if btn ();

    // The button pin is the single local control input.
    lbm_button #(
        .DEB_MS(DEB_MS),
        .LONG_MS(LONG_MS)
    ) u_button (
        .pclk(pclk),
        .presetn(presetn),
        .btn_n(btn_n),
        .bus(btn.src)
    );

    assign btn.tick = s_q.tick;

    // Segments lit for a level, one per full 20 percent step.
    function automatic logic [3:0] bar_of(input logic [6:0] pct);
        logic [3:0] b;
        b = 4'h0;
        if (pct >= LVL_SEG4)
        begin
            b = 4'hf;
        end
        else if (pct >= LVL_SEG3)
        begin
            b = 4'h7;
        end
        else if (pct >= LVL_SEG2)
        begin
            b = 4'h3;
        end
        else if (pct >= LVL_SEG1)
        begin
            b = 4'h1;
        end
        return b;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic access;
        logic rd_stat;
        logic light;
        logic lng;
        logic relight;
        logic show;
        logic push;
        logic [3:0] ev;
        logic [3:0] bar;
        access = psel && penable && !s_q.ready;
        rd_stat = 1'b0;
        light = btn.light_press;
        lng = btn.long_press;
        relight = light || lng;
        ev = 4'h0;
        show = 1'b0;
        bar = 4'h0;
        push = s_q.ctrl[CTRL_PUSH_BIT];
        s_d = s_q;

        // Millisecond tick and blink phases.
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == 17'(TICK_CYCLES - 1))
        begin
            s_d.tick_cnt = 17'h00000;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt + 17'h00001;
        end
        if (s_q.tick)
        begin
            s_d.fast_cnt = s_q.fast_cnt + 10'h001;
            s_d.slow_cnt = s_q.slow_cnt + 10'h001;
            if (s_q.fast_cnt == 10'(FAST_MS - 1))
            begin
                s_d.fast_cnt = 10'h000;
                s_d.fast = !s_q.fast;
            end
            if (s_q.slow_cnt == 10'(SLOW_MS - 1))
            begin
                s_d.slow_cnt = 10'h000;
                s_d.slow = !s_q.slow;
            end
        end

        // Press actions and mode walk.
        s_d.act = 5'h00;
        case (s_q.mode)
            LBM_NORMAL:
            begin
                s_d.act[ACT_BATT_READ] = light;
                if (lng)
                begin
                    s_d.mode = LBM_SURVEY;
                end
            end
            LBM_SURVEY:
            begin
                s_d.act[ACT_SURVEY_TX] = light;
                if (lng)
                begin
                    s_d.mode = LBM_OTA;
                end
            end
            LBM_OTA:
            begin
                if (ota_fail)
                begin
                    // A failed update answers the light press; a long press returns to normal only with batt_low and the OTA transmit bit clear.
                    s_d.act[ACT_OTA_RESET] = light;
                end
                else if (s_q.ctrl[CTRL_OTA_TX_BIT])
                begin
                    s_d.act[ACT_CFG_TX] = light;
                    s_d.act[ACT_FW_TX] = lng;
                end
                else
                begin
                    s_d.act[ACT_BATT_READ] = light && !batt_low;
                    if (lng)
                    begin
                        s_d.mode = LBM_NORMAL;
                    end
                end
                if (batt_low && !s_q.ctrl[CTRL_OTA_TX_BIT] && lng)
                begin
                    s_d.mode = LBM_NORMAL;
                end
            end
            default:
            begin
                s_d.mode = LBM_NORMAL;
            end
        endcase

        // Display lifetime on battery.
        if (relight || !on_battery)
        begin
            s_d.lit = 1'b1;
            s_d.dark_cnt = 16'h0000;
        end
        else if (s_q.lit && s_q.tick)
        begin
            if (s_q.dark_cnt == 16'(LIT_MS - 1))
            begin
                s_d.lit = 1'b0;
                ev[IRQ_DARK_BIT] = 1'b1;
            end
            else
            begin
                s_d.dark_cnt = s_q.dark_cnt + 16'h0001;
            end
        end
        show = s_q.lit || !on_battery;

        // LED drive.
        bar = s_q.ctrl[CTRL_BAR_SIG_BIT] ? bar_of(signal_pct) : bar_of(battery_pct);
        if (rf_error)
        begin
            bar[0] = s_q.fast;
        end
        if (io_error)
        begin
            bar[1] = s_q.fast;
        end
        s_d.st = 1'b0;
        s_d.rx = 1'b0;
        s_d.tx = 1'b0;
        case (s_q.mode)
            LBM_NORMAL:
            begin
                s_d.st = !node_ready ? s_q.fast : (push && s_q.slow);
                s_d.tx = tx_busy && push;
            end
            LBM_SURVEY:
            begin
                s_d.st = 1'b1;
                s_d.tx = tx_busy && push;
            end
            LBM_OTA:
            begin
                s_d.rx = !s_q.ctrl[CTRL_OTA_TX_BIT];
                s_d.tx = s_q.ctrl[CTRL_OTA_TX_BIT];
            end
            default:
            begin
                s_d.st = 1'b0;
            end
        endcase
        if (rf_error || io_error)
        begin
            s_d.er = s_q.fast;
        end
        else
        begin
            s_d.er = batt_low && s_q.slow;
        end
        s_d.st = s_d.st && show;
        s_d.er = s_d.er && show;
        s_d.rx = s_d.rx && show;
        s_d.tx = s_d.tx && show;
        s_d.bar = show ? bar : 4'h0;

        // APB slave, one wait state.
        s_d.ready = access;
        s_d.err = 1'b0;
        s_d.rdata = 32'h00000000;
        if (access)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    s_d.rdata = {29'h0, s_q.ctrl};
                    if (pwrite)
                    begin
                        s_d.ctrl = pwdata[CTRL_W-1:0];
                    end
                end
                OFS_MODE:
                begin
                    s_d.rdata = {28'h0, on_battery, s_q.lit, s_q.mode};
                end
                OFS_IRQ_STAT:
                begin
                    s_d.rdata = {28'h0, s_q.stat};
                    rd_stat = !pwrite;
                end
                OFS_IRQ_MASK:
                begin
                    s_d.rdata = {28'h0, s_q.mask};
                    if (pwrite)
                    begin
                        s_d.mask = pwdata[IRQ_W-1:0];
                    end
                end
                default:
                begin
                    s_d.err = 1'b1;
                end
            endcase
            if (pwrite)
            begin
                s_d.rdata = 32'h00000000;
            end
        end

        // Sticky events; a new event beats the read that clears.
        ev[IRQ_LIGHT_BIT] = light;
        ev[IRQ_LONG_BIT] = lng;
        ev[IRQ_MODE_BIT] = s_d.mode != s_q.mode;
        s_d.stat = (rd_stat ? 4'h0 : s_q.stat) | ev;
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.mode <= LBM_NORMAL;
            s_q.lit <= 1'b1;
            s_q.ctrl <= CTRL_RESET;
            s_q.mask <= IRQ_MASK_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign led_status = s_q.st;
    assign led_error = s_q.er;
    assign led_rx = s_q.rx;
    assign led_tx = s_q.tx;
    assign led_bar = s_q.bar;
    assign act = s_q.act;
    assign irq = s_q.irq;

endmodule // lbm_ctrl

// ---- dv/lbm_ctrl_chk.sv ----
// Concurrent checks on the ports of the LED and button mode controller.
// Assumes it is bound to lbm_ctrl with the same timing parameters.
`timescale 1ns/10ps
module lbm_ctrl_chk
    import lbm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned LIT_MS = LIT_TIMEOUT_MS,
    parameter int unsigned DEB_MS = DEBOUNCE_MS
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Panel
    input wire logic btn_n,
    input wire logic led_status,
    input wire logic led_error,
    input wire logic led_rx,
    input wire logic led_tx,
    input wire logic [3:0] led_bar,
    // Status and actions
    input wire logic on_battery,
    input wire logic tx_busy,
    input wire logic rf_error,
    input wire logic io_error,
    input wire logic [6:0] battery_pct,
    input wire logic [4:0] act
);
    // The dark bound allows for debounce and tick phase after the last release.
    localparam int unsigned DARK_LIM = (LIT_MS + DEB_MS + 6) * TICK_CYCLES;
    localparam int unsigned ACT_LIM = (DEB_MS + 3) * TICK_CYCLES + 8;
    logic [2:0] ctrl_q;
    int unsigned idle_q;
    int unsigned rel_q;

    function automatic logic [3:0] seg(input logic [6:0] p);
        return p >= LVL_SEG4 ? 4'hf : p >= LVL_SEG3 ? 4'h7 : p >= LVL_SEG2 ? 4'h3 :
            p >= LVL_SEG1 ? 4'h1 : 4'h0;
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
            idle_q <= 0;
            rel_q <= 0;
        end
        else
        begin
            if (psel && penable && !pready && pwrite && paddr == OFS_CTRL)
            begin
                ctrl_q <= pwdata[2:0];
            end
            idle_q <= (!on_battery || !btn_n) ? 0 : (idle_q < DARK_LIM ? idle_q + 1 : idle_q);
            rel_q <= !btn_n ? 0 : (rel_q <= ACT_LIM ? rel_q + 1 : rel_q);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable && !pready;
    endsequence

    a_apb_answer: assert property (s_access |=> pready)
        else $error("apb access not answered after one wait state");
    a_act_single: assert property (act != 0 |-> $onehot(act) ##1 act == 0)
        else $error("action pulse not single");
    a_act_cause: assert property (act != 0 |-> rel_q <= ACT_LIM)
        else $error("action without a button press");
    a_tx_cause: assert property (led_tx |-> $past(tx_busy && ctrl_q[0]) || $past(ctrl_q[2]))
        else $error("transmit led without cause");
    a_rx_excl: assert property (led_rx |-> !led_tx && !$past(ctrl_q[2]))
        else $error("receive led with transmit state");
    a_bar_level: assert property (!$past(rf_error || io_error || ctrl_q[1]) |->
        led_bar == 4'h0 || led_bar == seg($past(battery_pct)))
        else $error("bar does not match battery level");
    a_dark_timeout: assert property (idle_q == DARK_LIM |->
        {led_status, led_error, led_rx, led_tx, led_bar} == 8'h00)
        else $error("leds still lit after battery timeout");
endmodule // lbm_ctrl_chk

bind lbm_ctrl lbm_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES), .LIT_MS(LIT_MS), .DEB_MS(DEB_MS)) u_chk (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .btn_n,
    .led_status, .led_error, .led_rx, .led_tx, .led_bar, .on_battery, .tx_busy,
    .rf_error, .io_error, .battery_pct, .act);

// ---- dv/lbm_operator.sv ----
// Model of the operator at the front panel, driving the one button pin.
// Assumes an active-low pin and press lengths given in millisecond ticks.
`timescale 1ns/10ps
module lbm_operator #(
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned DEB_MS = 2
)
(
    // Clock
    input wire logic pclk,
    // Button pin
    output logic btn_n
);
    initial btn_n = 1'b1;

    // The membrane contact chatters once on closing, so the debouncer is exercised.
    task automatic press(input int unsigned ms);
        @(posedge pclk);
        btn_n <= 1'b0;
        @(posedge pclk);
        btn_n <= 1'b1;
        @(posedge pclk);
        btn_n <= 1'b0;
        repeat (ms * TICK_CYCLES) @(posedge pclk);
        btn_n <= 1'b1;
        repeat ((DEB_MS + 3) * TICK_CYCLES) @(posedge pclk);
    endtask
endmodule // lbm_operator

// ---- dv/tb.sv ----
// Self-checking bench of the LED and button mode controller.
// Assumes short timing parameters so that timeouts fit in a short run.
`timescale 1ns/10ps
module tb;
    import lbm_pkg::*;
    localparam int unsigned TK = 4;
    localparam int unsigned LIT = 20;
    localparam int unsigned DEB = 2;
    localparam int unsigned LNG = 10;
    localparam int unsigned SHORT = DEB + 3;
    localparam int unsigned HOLD = LNG + DEB + 3;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic on_battery = 1'b0, node_ready = 1'b0, tx_busy = 1'b0, rf_error = 1'b0;
    logic io_error = 1'b0, batt_low = 1'b0, ota_fail = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [6:0] battery_pct = 7'h00, signal_pct = 7'h00;
    logic pready, pslverr, btn_n, led_status, led_error, led_rx, led_tx, irq;
    logic [3:0] led_bar;
    logic [4:0] act, seen = 5'h00;
    int failures = 0, samples_checked = 0, seed = 26, v;
    int lims[8] = '{19, 20, 39, 40, 59, 60, 79, 80};

    lbm_ctrl #(.TICK_CYCLES(TK), .LIT_MS(LIT), .DEB_MS(DEB), .LONG_MS(LNG), .FAST_MS(2),
        .SLOW_MS(4)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .btn_n, .led_status, .led_error, .led_rx, .led_tx, .led_bar,
        .on_battery, .node_ready, .tx_busy, .rf_error, .io_error, .batt_low, .ota_fail,
        .battery_pct, .signal_pct, .act, .irq);
    lbm_operator #(.TICK_CYCLES(TK), .DEB_MS(DEB)) OP (.pclk, .btn_n);

    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) if (act !== 5'h00) seen <= seen | act;

    function automatic logic [3:0] bar(input int p);
        return p >= 80 ? 4'hf : p >= 60 ? 4'h7 : p >= 40 ? 4'h3 : p >= 20 ? 4'h1 : 4'h0;
    endfunction

    task automatic finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask

    // A lost answer counts as a mismatch and ends the run at once.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
        begin
            chk(1'b0, 1'b1, "apb timeout");
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pr(input int unsigned ms, input logic [4:0] ea, input logic [1:0] em);
        seen <= 5'h00;
        OP.press(ms);
        chk(seen, ea, "action");
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rd[1:0], em, "mode");
    endtask

    task automatic txc(input logic b, input logic [2:0] c, input logic e);
        tx_busy <= b;
        apb(1'b1, OFS_CTRL, {29'h0, c});
        chk(led_tx, e, "transmit led");
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        node_ready <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rd, 32'h4, "mode reset");
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        chk(rd, 32'h0, "mask reset");
        apb(1'b1, 12'h010, 32'hffffffff);
        chk(err, 1'b1, "unmapped");
        apb(1'b1, OFS_MODE, 32'h3);
        apb(1'b1, OFS_CTRL, 32'hfffffff9);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1, "ctrl width");
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rd, 32'h4, "mode read only");
        $display("registers done");
        for (int i = 0; i < 16; i++)
        begin
            v = i < 8 ? lims[i] : $unsigned($random(seed)) % 101;
            battery_pct <= v[6:0];
            signal_pct <= 7'(100 - v);
            apb(1'b1, OFS_CTRL, {30'h0, i[0], 1'b0});
            chk(led_bar, bar(i[0] ? 100 - v : v), "bar");
        end
        $display("bar done");
        battery_pct <= 7'd100;
        apb(1'b1, OFS_CTRL, 32'h0);
        pr(SHORT, 5'h01 << ACT_BATT_READ, LBM_NORMAL);
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        chk(irq, 1'b1, "irq raised");
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(rd[3:0], 4'h1, "status");
        @(posedge pclk);
        chk(irq, 1'b0, "irq cleared");
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        $display("interrupt done");
        pr(HOLD, 5'h00, LBM_SURVEY);
        chk(led_status, 1'b1, "survey status");
        txc(1'b1, 3'h1, 1'b1);
        txc(1'b1, 3'h0, 1'b0);
        pr(SHORT, 5'h01 << ACT_SURVEY_TX, LBM_SURVEY);
        pr(HOLD, 5'h00, LBM_OTA);
        chk(led_rx, 1'b1, "receive led");
        pr(SHORT, 5'h01 << ACT_BATT_READ, LBM_OTA);
        batt_low <= 1'b1;
        pr(SHORT, 5'h00, LBM_OTA);
        batt_low <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h4);
        pr(SHORT, 5'h01 << ACT_CFG_TX, LBM_OTA);
        pr(HOLD, 5'h01 << ACT_FW_TX, LBM_OTA);
        apb(1'b1, OFS_CTRL, 32'h0);
        ota_fail <= 1'b1;
        pr(SHORT, 5'h01 << ACT_OTA_RESET, LBM_OTA);
        pr(HOLD, 5'h00, LBM_OTA);
        ota_fail <= 1'b0;
        pr(HOLD, 5'h00, LBM_NORMAL);
        txc(1'b1, 3'h1, 1'b1);
        txc(1'b0, 3'h1, 1'b0);
        txc(1'b1, 3'h0, 1'b0);
        $display("modes done");
        on_battery <= 1'b1;
        pr(SHORT, 5'h01 << ACT_BATT_READ, LBM_NORMAL);
        repeat ((LIT - 6) * TK) @(posedge pclk);
        chk(led_bar, 4'hf, "lit before timeout");
        repeat (12 * TK) @(posedge pclk);
        chk({led_status, led_error, led_rx, led_tx, led_bar}, 8'h00, "dark");
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rd[3:2], 2'b10, "dark flag");
        on_battery <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(led_bar, 4'hf, "line power lit");
        $display("timeout done");
        finish_test();
    end
endmodule // tb
